// *** dmrc_pkg.sv ***
// constants, field layout and carrier types for loop mode and reference control
package dmrc_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int FAIL_W = 4;
  localparam int PRIO_W = 3;

  localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h42;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h43;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h44;

  localparam logic [DATA_W-1:0] RESET_MODE = 8'h03;
  localparam logic [DATA_W-1:0] RESET_MASK = 8'h87;
  localparam logic [DATA_W-1:0] RESET_STATUS = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 1;
  localparam int FB_EN_BIT = 5;
  localparam int REFSEL_LSB = 6;
  localparam int REFSEL_MSB = 7;
  localparam int HOLD_MASK_LSB = 0;
  localparam int HOLD_MASK_MSB = 3;
  localparam int SW_MASK_LSB = 4;
  localparam int SW_MASK_MSB = 7;
  localparam int STAT_HOLD_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;

  localparam logic [1:0] MODE_FREERUN = 2'h0;
  localparam logic [1:0] MODE_FORCED_HOLD = 2'h1;
  localparam logic [1:0] MODE_FORCED_REF = 2'h2;
  localparam logic [1:0] MODE_AUTO = 2'h3;

  localparam logic [1:0] REFSEL_ZERO = 2'h0;
  localparam logic [1:0] REFSEL_ONE = 2'h1;
  localparam logic [PRIO_W-1:0] PRIO_DISABLED = 3'h7;

  typedef struct packed {
    logic guard_timer;
    logic coarse_freq;
    logic single_cycle;
    logic signal_loss_detect;
  } dmrc_fail_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dmrc_reg_req_t;

  typedef enum logic [1:0] {
    LOOP_FREERUN,
    LOOP_LOCKED,
    LOOP_HOLDOVER
  } dmrc_loop_state_t;

endpackage : dmrc_pkg

// *** dmrc_ref_picker.sv ***
// automatic reference choice from availability and priority
`timescale 1ns/10ps
module dmrc_ref_picker #(
  parameter int PRIO_W = dmrc_pkg::PRIO_W
) (
  input wire logic [1:0] avail,
  input wire logic [PRIO_W-1:0] prio_zero,
  input wire logic [PRIO_W-1:0] prio_one,
  input wire logic cur_ref,
  output logic next_ref,
  output logic any_avail
);
  logic use_zero;
  logic use_one;

  always_comb begin
    // a disabled priority removes the reference from the choice
    use_zero = avail[0] && (prio_zero != dmrc_pkg::PRIO_DISABLED);
    use_one = avail[1] && (prio_one != dmrc_pkg::PRIO_DISABLED);
    any_avail = use_zero || use_one;
    next_ref = cur_ref;
    if (use_zero && use_one) begin
      if (prio_zero < prio_one) begin
        next_ref = 1'b0;
      end else if (prio_one < prio_zero) begin
        next_ref = 1'b1;
      end
    end else if (use_zero) begin
      next_ref = 1'b0;
    end else if (use_one) begin
      next_ref = 1'b1;
    end
  end

endmodule : dmrc_ref_picker

// *** dmrc_mode_ctrl.sv ***
// loop mode, reference selection, failure masks and sticky loop status
//
// Operation
// - mode field: 00 free-run, 01 forced holdover, 10 forced lock, 11 automatic.
// - mode field sits in bits 1:0; register resets to automatic mode.
// - automatic mode picks by availability and priority; holdover only when none available.
// - forced lock uses only the programmed reference; on its failure go holdover.
// - forced holdover ignores references and keeps the last selected reference.
// - free-run derives outputs only from the local oscillator input.
// - bit 5 set applies external feedback phase compensation; clear ignores it.
// - one shared feedback input, used whenever enabled, whatever loop produces it.
// - in automatic mode bits 7:6 read as the selected reference, read-only.
// - in forced mode bits 7:6 choose the forced reference, 00 zero, 01 one.
// - free-run and forced holdover ignore the reference selection field.
// - a zero holdover mask bit blocks holdover for that failure type.
// - a zero switch mask bit blocks reference switching for that failure type.
// - status bit 0 shows holdover and cannot be masked.
// - status bit 1 shows lock to a reference and cannot be masked.
// - differing priorities revert to the lowest number; equal priorities do not.
`timescale 1ns/10ps
module dmrc_mode_ctrl #(
  parameter int FB_W = 16,
  parameter int PRIO_W = dmrc_pkg::PRIO_W
) (
  input wire logic clock,
  input wire logic srst,
  input wire dmrc_pkg::dmrc_reg_req_t reg_req,
  output logic [dmrc_pkg::DATA_W-1:0] reg_rdata,
  input wire dmrc_pkg::dmrc_fail_t [1:0] ref_fail,
  input wire logic [PRIO_W-1:0] prio_zero,
  input wire logic [PRIO_W-1:0] prio_one,
  input wire logic [FB_W-1:0] fb_phase,
  output logic [FB_W-1:0] fb_phase_comp,
  output logic loop_feedback_compensation_en,
  output dmrc_pkg::dmrc_loop_state_t loop_state,
  output logic selected_ref,
  output logic oscillator_input_only
);

  // any failure type whose mask bit is one counts
  function automatic logic masked_fail(input dmrc_pkg::dmrc_fail_t f,
                                       input logic [dmrc_pkg::FAIL_W-1:0] m);
    masked_fail = |(f & m);
  endfunction : masked_fail

  logic [dmrc_pkg::DATA_W-1:0] mode_reg;
  logic [dmrc_pkg::DATA_W-1:0] mode_next;
  logic [dmrc_pkg::DATA_W-1:0] mask_reg;
  logic [dmrc_pkg::DATA_W-1:0] mask_next;
  logic [dmrc_pkg::DATA_W-1:0] status_reg;
  logic [dmrc_pkg::DATA_W-1:0] status_next;
  logic [dmrc_pkg::DATA_W-1:0] rdata_reg;
  logic [dmrc_pkg::DATA_W-1:0] rdata_next;
  dmrc_pkg::dmrc_loop_state_t state_reg;
  dmrc_pkg::dmrc_loop_state_t state_next;
  logic sel_reg;
  logic sel_next;
  logic osc_reg;
  logic osc_next;
  logic [FB_W-1:0] fb_reg;
  logic [FB_W-1:0] fb_next;

  logic [1:0] mode;
  logic forced_ref;
  logic [dmrc_pkg::FAIL_W-1:0] hold_mask;
  logic [dmrc_pkg::FAIL_W-1:0] sw_mask;
  logic [1:0] avail;
  logic [1:0] hold_fail;
  logic pick_ref;
  logic pick_any;
  logic wr_mode;
  logic wr_mask;
  logic rd_status;

  assign mode = mode_reg[dmrc_pkg::MODE_MSB:dmrc_pkg::MODE_LSB];
  // only bit 6 steers the forced choice; code 10 acts as reference zero, 11 as one
  assign forced_ref = mode_reg[dmrc_pkg::REFSEL_LSB];
  assign hold_mask = mask_reg[dmrc_pkg::HOLD_MASK_MSB:dmrc_pkg::HOLD_MASK_LSB];
  assign sw_mask = mask_reg[dmrc_pkg::SW_MASK_MSB:dmrc_pkg::SW_MASK_LSB];
  assign wr_mode = reg_req.wr && (reg_req.addr == dmrc_pkg::ADDR_MODE);
  assign wr_mask = reg_req.wr && (reg_req.addr == dmrc_pkg::ADDR_MASK);
  assign rd_status = reg_req.rd && (reg_req.addr == dmrc_pkg::ADDR_STATUS);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ref
      assign avail[gi] = !masked_fail(ref_fail[gi], sw_mask);
      assign hold_fail[gi] = masked_fail(ref_fail[gi], hold_mask);
    end
  endgenerate

  dmrc_ref_picker #(
    .PRIO_W(PRIO_W)
  ) u_picker (
    .avail(avail),
    .prio_zero(prio_zero),
    .prio_one(prio_one),
    .cur_ref(sel_reg),
    .next_ref(pick_ref),
    .any_avail(pick_any)
  );

  // register writes
  always_comb begin
    mode_next = mode_reg;
    mask_next = mask_reg;
    if (wr_mode) begin
      mode_next = ZERO_MODE(reg_req.wdata, mode_reg);
    end
    if (wr_mask) begin
      mask_next = reg_req.wdata;
    end
  end

  // reserved bits stay zero; the select field is read-only while automatic
  function automatic logic [dmrc_pkg::DATA_W-1:0] ZERO_MODE(
      input logic [dmrc_pkg::DATA_W-1:0] wd, input logic [dmrc_pkg::DATA_W-1:0] old);
    ZERO_MODE = dmrc_pkg::ZERO_BYTE;
    ZERO_MODE[dmrc_pkg::MODE_MSB:dmrc_pkg::MODE_LSB] = wd[dmrc_pkg::MODE_MSB:dmrc_pkg::MODE_LSB];
    ZERO_MODE[dmrc_pkg::FB_EN_BIT] = wd[dmrc_pkg::FB_EN_BIT];
    if (wd[dmrc_pkg::MODE_MSB:dmrc_pkg::MODE_LSB] == dmrc_pkg::MODE_AUTO) begin
      ZERO_MODE[dmrc_pkg::REFSEL_MSB:dmrc_pkg::REFSEL_LSB] =
        old[dmrc_pkg::REFSEL_MSB:dmrc_pkg::REFSEL_LSB];
    end else begin
      ZERO_MODE[dmrc_pkg::REFSEL_MSB:dmrc_pkg::REFSEL_LSB] =
        wd[dmrc_pkg::REFSEL_MSB:dmrc_pkg::REFSEL_LSB];
    end
  endfunction : ZERO_MODE

  always_ff @(posedge clock) begin
    if (srst) begin
      mode_reg <= dmrc_pkg::RESET_MODE;
      mask_reg <= dmrc_pkg::RESET_MASK;
    end else begin
      mode_reg <= mode_next;
      mask_reg <= mask_next;
    end
  end

  // loop state and reference selection
  always_comb begin
    state_next = state_reg;
    sel_next = sel_reg;
    osc_next = 1'b0;
    case (mode)
      dmrc_pkg::MODE_FREERUN: begin
        state_next = dmrc_pkg::LOOP_FREERUN;
        osc_next = 1'b1;
      end
      dmrc_pkg::MODE_FORCED_HOLD: begin
        state_next = dmrc_pkg::LOOP_HOLDOVER;
      end
      dmrc_pkg::MODE_FORCED_REF: begin
        sel_next = forced_ref;
        // a masked failure leaves the loop on the forced reference
        state_next = hold_fail[forced_ref] ? dmrc_pkg::LOOP_HOLDOVER
                                           : dmrc_pkg::LOOP_LOCKED;
      end
      dmrc_pkg::MODE_AUTO: begin
        if (pick_any) begin
          sel_next = pick_ref;
          state_next = dmrc_pkg::LOOP_LOCKED;
        end else if (hold_fail[sel_reg]) begin
          state_next = dmrc_pkg::LOOP_HOLDOVER;
        end else begin
          // nothing can be switched to and holdover is masked: stay on it
          state_next = dmrc_pkg::LOOP_LOCKED;
        end
      end
      default: begin
        state_next = dmrc_pkg::LOOP_FREERUN;
      end
    endcase
    // one shared feedback input, gated only by the enable bit
    fb_next = mode_reg[dmrc_pkg::FB_EN_BIT] ? fb_phase : '0;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= dmrc_pkg::LOOP_FREERUN;
      sel_reg <= 1'b0;
      osc_reg <= 1'b0;
      fb_reg <= '0;
    end else begin
      state_reg <= state_next;
      sel_reg <= sel_next;
      osc_reg <= osc_next;
      fb_reg <= fb_next;
    end
  end

  // sticky status and read data; a set in the reading cycle wins over the clear
  always_comb begin
    status_next = status_reg;
    if (rd_status) begin
      status_next = dmrc_pkg::ZERO_BYTE;
    end
    if (state_reg == dmrc_pkg::LOOP_HOLDOVER) begin
      status_next[dmrc_pkg::STAT_HOLD_BIT] = 1'b1;
    end
    if (state_reg == dmrc_pkg::LOOP_LOCKED) begin
      status_next[dmrc_pkg::STAT_LOCK_BIT] = 1'b1;
    end
    rdata_next = dmrc_pkg::ZERO_BYTE;
    if (reg_req.rd) begin
      case (reg_req.addr)
        dmrc_pkg::ADDR_MODE: begin
          rdata_next = mode_reg;
          if (mode == dmrc_pkg::MODE_AUTO) begin
            rdata_next[dmrc_pkg::REFSEL_MSB:dmrc_pkg::REFSEL_LSB] =
              sel_reg ? dmrc_pkg::REFSEL_ONE : dmrc_pkg::REFSEL_ZERO;
          end
        end
        dmrc_pkg::ADDR_MASK: rdata_next = mask_reg;
        dmrc_pkg::ADDR_STATUS: rdata_next = status_reg;
        default: rdata_next = dmrc_pkg::ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      status_reg <= dmrc_pkg::RESET_STATUS;
      rdata_reg <= dmrc_pkg::ZERO_BYTE;
    end else begin
      status_reg <= status_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign fb_phase_comp = fb_reg;
  assign loop_feedback_compensation_en = mode_reg[dmrc_pkg::FB_EN_BIT];
  assign loop_state = state_reg;
  assign selected_ref = sel_reg;
  assign oscillator_input_only = osc_reg;

  chk_freerun_state: assert property (@(posedge clock) disable iff (srst)
    (mode == dmrc_pkg::MODE_FREERUN) |=> (loop_state == dmrc_pkg::LOOP_FREERUN)
      && oscillator_input_only)
    else $error("free-run mode did not reach free-run state");

  chk_forced_hold: assert property (@(posedge clock) disable iff (srst)
    (mode == dmrc_pkg::MODE_FORCED_HOLD) |=> (loop_state == dmrc_pkg::LOOP_HOLDOVER)
      && (selected_ref == $past(selected_ref)))
    else $error("forced holdover changed reference or left holdover");

  chk_forced_ref: assert property (@(posedge clock) disable iff (srst)
    (mode == dmrc_pkg::MODE_FORCED_REF) |=> (selected_ref == $past(forced_ref))
      && (loop_state != dmrc_pkg::LOOP_FREERUN))
    else $error("forced lock did not use the programmed reference");

  chk_auto_lock: assert property (@(posedge clock) disable iff (srst)
    (mode == dmrc_pkg::MODE_AUTO) && pick_any |=> (loop_state == dmrc_pkg::LOOP_LOCKED))
    else $error("automatic mode entered holdover with a reference available");

  chk_revert_prio: assert property (@(posedge clock) disable iff (srst)
    (mode == dmrc_pkg::MODE_AUTO) && (avail == 2'h3) && (prio_zero < prio_one)
      |=> !selected_ref)
    else $error("automatic mode did not revert to the better reference");

  chk_reserved_zero: assert property (@(posedge clock) disable iff (srst)
    mode_reg[dmrc_pkg::FB_EN_BIT-1:dmrc_pkg::MODE_MSB+1] == '0)
    else $error("reserved mode bits became nonzero");

  chk_fb_gate: assert property (@(posedge clock) disable iff (srst)
    !mode_reg[dmrc_pkg::FB_EN_BIT] |=> (fb_phase_comp == '0))
    else $error("feedback phase passed while disabled");

  chk_auto_status: assert property (@(posedge clock) disable iff (srst)
    reg_req.rd && (reg_req.addr == dmrc_pkg::ADDR_MODE) && (mode == dmrc_pkg::MODE_AUTO)
      |=> (reg_rdata[dmrc_pkg::REFSEL_MSB:dmrc_pkg::REFSEL_LSB] == {1'b0, $past(sel_reg)}))
    else $error("selected reference not shown in automatic mode");

  chk_sticky_hold: assert property (@(posedge clock) disable iff (srst)
    (loop_state == dmrc_pkg::LOOP_HOLDOVER) |=> status_reg[dmrc_pkg::STAT_HOLD_BIT])
    else $error("holdover status bit not set");

  chk_sticky_keep: assert property (@(posedge clock) disable iff (srst)
    status_reg[dmrc_pkg::STAT_LOCK_BIT] && !rd_status |=> status_reg[dmrc_pkg::STAT_LOCK_BIT])
    else $error("lock status bit cleared without a read");

  chk_fb_pass: assert property (@(posedge clock) disable iff (srst)
    mode_reg[dmrc_pkg::FB_EN_BIT] |=> (fb_phase_comp == $past(fb_phase)))
    else $error("enabled feedback phase not passed on");

  chk_sticky_lock: assert property (@(posedge clock) disable iff (srst)
    (loop_state == dmrc_pkg::LOOP_LOCKED) |=> status_reg[dmrc_pkg::STAT_LOCK_BIT])
    else $error("lock status bit not set");

  chk_refsel_ignored: assert property (@(posedge clock) disable iff (srst)
    (mode == dmrc_pkg::MODE_FREERUN) || (mode == dmrc_pkg::MODE_FORCED_HOLD)
      |=> (selected_ref == $past(selected_ref)))
    else $error("selection field acted outside forced and automatic modes");

  chk_hold_masked: assert property (@(posedge clock) disable iff (srst)
    (mode == dmrc_pkg::MODE_FORCED_REF) && !hold_fail[forced_ref]
      |=> (loop_state == dmrc_pkg::LOOP_LOCKED))
    else $error("masked failure sent the forced loop to holdover");

endmodule : dmrc_mode_ctrl

// *** dmrc_ref_model.sv ***
// far side model: reference failure flags, priorities and a moving feedback phase
`timescale 1ns/10ps
module dmrc_ref_model (
  input wire logic clock,
  input wire dmrc_pkg::dmrc_fail_t [1:0] fail_cmd,
  input wire logic [5:0] prio_cmd,
  output dmrc_pkg::dmrc_fail_t [1:0] ref_fail,
  output logic [2:0] prio_zero,
  output logic [2:0] prio_one,
  output logic [15:0] fb_phase
);
  initial begin
    ref_fail = '0;
    prio_zero = 3'h0;
    prio_one = 3'h1;
    fb_phase = 16'h1234;
  end
  // the phase moves every cycle so a stale or stuck copy cannot match
  always @(negedge clock) begin
    ref_fail <= fail_cmd;
    prio_zero <= prio_cmd[2:0];
    prio_one <= prio_cmd[5:3];
    fb_phase <= fb_phase + 16'h0101;
  end
endmodule : dmrc_ref_model

// *** dmrc_mode_ctrl_tb_top.sv ***
// self-checking bench for loop mode and reference control
`timescale 1ns/10ps
module dmrc_mode_ctrl_tb_top;
  localparam logic [7:0] A_MODE = dmrc_pkg::ADDR_MODE;
  localparam logic [7:0] A_MASK = dmrc_pkg::ADDR_MASK;
  localparam logic [7:0] A_STAT = dmrc_pkg::ADDR_STATUS;
  localparam logic [1:0] FREE = dmrc_pkg::LOOP_FREERUN;
  localparam logic [1:0] LOCK = dmrc_pkg::LOOP_LOCKED;
  localparam logic [1:0] HOLD = dmrc_pkg::LOOP_HOLDOVER;
  logic clock = 1'b0;
  logic srst = 1'b1;
  dmrc_pkg::dmrc_reg_req_t req = '0;
  dmrc_pkg::dmrc_fail_t [1:0] fail_cmd = '0;
  logic [5:0] prio_cmd = 6'h08;
  dmrc_pkg::dmrc_fail_t [1:0] ref_fail;
  dmrc_pkg::dmrc_loop_state_t state;
  logic [7:0] rdata;
  logic [2:0] prio_zero;
  logic [2:0] prio_one;
  logic [15:0] fb_phase;
  logic [15:0] fb_comp;
  logic fb_en;
  logic sel;
  logic osc_only;
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;

  always #10 clock = ~clock;

  dmrc_ref_model u_ref (
    .clock(clock),
    .fail_cmd(fail_cmd),
    .prio_cmd(prio_cmd),
    .ref_fail(ref_fail),
    .prio_zero(prio_zero),
    .prio_one(prio_one),
    .fb_phase(fb_phase)
  );

  dmrc_mode_ctrl u_dut (
    .clock(clock),
    .srst(srst),
    .reg_req(req),
    .reg_rdata(rdata),
    .ref_fail(ref_fail),
    .prio_zero(prio_zero),
    .prio_one(prio_one),
    .fb_phase(fb_phase),
    .fb_phase_comp(fb_comp),
    .loop_feedback_compensation_en(fb_en),
    .loop_state(state),
    .selected_ref(sel),
    .oscillator_input_only(osc_only)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick

  // state follows a write one edge after the register, so two spare cycles cover it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    req = '{1'b1, 1'b0, a, d};
    @(negedge clock);
    req = '0;
    tick(2);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clock);
    req = '0;
    check({8'h00, rdata}, {8'h00, exp});
  endtask : rd

  // the model takes the flags on a falling edge, so allow three cycles to settle
  task automatic fail(input logic [3:0] f0, input logic [3:0] f1);
    fail_cmd = {f1, f0};
    tick(3);
  endtask : fail

  task automatic loop_is(input logic [1:0] s, input logic r);
    check({14'h0000, state}, {14'h0000, s});
    check({15'h0000, sel}, {15'h0000, r});
  endtask : loop_is

  task automatic tend(input string s);
    $display("test %s ended, errors %0d", s, error_cnt);
  endtask : tend

  task automatic test_done;
    $display("checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      test_done();
    end
  end

  initial begin
    repeat (5) @(negedge clock);
    srst = 1'b0;
    // taken at the first edge out of reset, the edge at which the loop locks, before the lock status bit can be set
    req = '{1'b0, 1'b1, A_STAT, 8'h00};
    @(negedge clock);
    req = '0;
    check({8'h00, rdata}, 16'h0000);
    rd(A_MODE, 8'h03);
    rd(A_MASK, 8'h87);
    wr(8'h50, 8'hFF);
    rd(8'h50, 8'h00);
    loop_is(LOCK, 1'b0);
    rd(A_STAT, 8'h02);
    tend("reset");
    wr(A_MODE, 8'hC0);
    loop_is(FREE, 1'b0);
    check({15'h0000, osc_only}, 16'h0001);
    rd(A_STAT, 8'h02);
    rd(A_STAT, 8'h00);
    wr(A_MODE, 8'h01);
    loop_is(HOLD, 1'b0);
    check({15'h0000, osc_only}, 16'h0000);
    rd(A_STAT, 8'h01);
    tend("free and hold");
    wr(A_MODE, 8'h42);
    loop_is(LOCK, 1'b1);
    rd(A_MODE, 8'h42);
    fail(4'h0, 4'h1);
    loop_is(HOLD, 1'b1);
    fail(4'h0, 4'h0);
    loop_is(LOCK, 1'b1);
    rd(A_STAT, 8'h03);
    rd(A_STAT, 8'h02);
    tend("forced");
    wr(A_MODE, 8'h43);
    loop_is(LOCK, 1'b0);
    rd(A_MODE, 8'h03);
    fail(4'h1, 4'h0);
    loop_is(LOCK, 1'b0);
    fail(4'h9, 4'h0);
    loop_is(LOCK, 1'b1);
    rd(A_MODE, 8'h43);
    fail(4'h0, 4'h0);
    loop_is(LOCK, 1'b0);
    prio_cmd = 6'h12;
    fail(4'h8, 4'h0);
    loop_is(LOCK, 1'b1);
    fail(4'h0, 4'h0);
    loop_is(LOCK, 1'b1);
    tend("auto");
    fail(4'h8, 4'h8);
    loop_is(LOCK, 1'b1);
    wr(A_MASK, 8'h8F);
    rd(A_MASK, 8'h8F);
    loop_is(HOLD, 1'b1);
    wr(A_MODE, 8'h01);
    fail(4'h0, 4'h0);
    loop_is(HOLD, 1'b1);
    tend("masks");
    wr(A_MODE, 8'h23);
    check({15'h0000, fb_en}, 16'h0001);
    for (int i = 0; i < 3; i++) begin
      @(negedge clock);
      check(fb_comp, fb_phase);
    end
    wr(A_MODE, 8'h03);
    check({15'h0000, fb_en}, 16'h0000);
    check(fb_comp, 16'h0000);
    tend("feedback");
    test_done();
  end
endmodule : dmrc_mode_ctrl_tb_top
